// File: shared/crf_pkg.sv
// Purpose: constants for the counter read-freeze and run-output block
// Assumes: 20 MHz system clock
// Notes:   timing counts are derived from times in their own units
package crf_pkg;
  localparam int CLK_HZ          = 20_000_000;
  localparam int CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int FREEZE_NS       = 120;
  // least time: round up
  localparam int FREEZE_CYC      = (FREEZE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RUN_GAP_NS      = 120;
  localparam int RUN_GAP_CYC     = (RUN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_US         = 1;
  localparam int TICK_CYC        = TICK_US * (CLK_HZ / 1_000_000);
  localparam int STRETCH_US      = 10;
  localparam int STRETCH_TICKS   = STRETCH_US / TICK_US;
  localparam int BUTTON_MS       = 3000;
  localparam int BUTTON_TICKS    = BUTTON_MS * 1000 / TICK_US;
  localparam int CNT_W           = 32;
  localparam int TIMER_W         = 40;
  localparam logic [15:0] REPLY_EN = 16'h454E;
  localparam logic [15:0] REPLY_DS = 16'h4453;
  typedef enum logic [1:0] {CRF_IDLE, CRF_FREEZE, CRF_LATCH} crf_frz_type;
endpackage

// File: rtl/crf_pulse_stretch.sv
// Purpose: minimum-width stretcher for the run output
// Assumes: tick_i is a one-cycle 1 us enable
// Notes:   an edge is copied out, then the output is held for the minimum time
`timescale 1ns/1ns
module crf_pulse_stretch
  import crf_pkg::*;
#(
  parameter int MIN_TICKS = STRETCH_TICKS
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic tick_i,
  input  wire logic enable_i,
  input  wire logic level_i,
  output logic      level_o
);
  logic [7:0] hold_r;
  logic       out_r;
  // a change seen during the hold is kept so that a short pulse is not swallowed
  logic       seen_r;

  assign level_o = out_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_r  <= 1'b0;
      hold_r <= 8'h00;
      seen_r <= 1'b0;
    end else if (!enable_i) begin
      out_r  <= level_i;
      hold_r <= 8'h00;
      seen_r <= 1'b0;
    end else if (hold_r != 8'h00) begin
      if (level_i != out_r) begin
        seen_r <= 1'b1;
      end
      // the ticks count whole microseconds, so the hold may run up to one tick longer
      if (tick_i) begin
        hold_r <= hold_r - 8'h01;
      end
    end else if (level_i != out_r || seen_r) begin
      out_r  <= !out_r;
      hold_r <= 8'(MIN_TICKS + 1);
      seen_r <= 1'b0;
    end
  end

  a_stretch_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    enable_i && $past(enable_i) && $changed(out_r) |-> hold_r != 8'h00)
    else $error("stretch hold not started on output edge");
endmodule

// File: rtl/crf_core.sv
// Function
// - any data-read command freezes all channels and timer for 120 ns; here count_en_o stays low 4 cycles (200 ns)
// - during the freeze every 32-bit count is latched into a holding register
// - freeze covers all counters and timer, always exactly 120 ns; here always 4 cycles (200 ns)
// - in stop modes the timer pauses too so the window stays exact
// - run output is active while the counter operates
// - run output drops at least 120 ns between back-to-back intervals
// - with stretching on, pulses or gaps under 10 us become 10 us
// - disable command turns stretching off, output follows run state
// - status query answers two letters, enabled or disabled
// - with auto-stop disabled, only stop command or trigger ends counting
// - only the unit receiving a read freezes; others keep counting
// - button held 3 s enters write mode, shorter press resets
// - gate high or open enables counting, polarity selectable
//
// Purpose: read freeze, run state and run output control
// Assumes: commands are one-cycle pulses synchronous to clk_i
// Notes:   the count datapath sits outside and obeys count_en_o
`timescale 1ns/1ns
module crf_core
  import crf_pkg::*;
#(
  parameter int CHANNELS     = 8,
  parameter int BUTTON_LIMIT = BUTTON_TICKS
) (
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      read_cmd_i,
  input  wire logic [CHANNELS*CNT_W-1:0] count_i,
  input  wire logic                      start_cmd_i,
  input  wire logic                      stop_cmd_i,
  input  wire logic                      stop_trig_i,
  input  wire logic                      limit_hit_i,
  input  wire logic                      auto_stop_disable_cmd_i,
  input  wire logic                      auto_stop_enable_cmd_i,
  input  wire logic                      interval_end_i,
  input  wire logic                      gate_i,
  input  wire logic                      gate_invert_i,
  input  wire logic                      run_invert_i,
  input  wire logic                      pulse_stretch_enable_cmd_i,
  input  wire logic                      pulse_stretch_disable_cmd_i,
  input  wire logic                      pulse_stretch_status_query_i,
  input  wire logic                      reset_writemode_button_i,
  output logic                           count_en_o,
  output logic                           timer_en_o,
  output logic [CHANNELS*CNT_W-1:0]      latch_o,
  output logic                           latch_valid_o,
  output logic                           run_o,
  output logic [15:0]                    status_reply_o,
  output logic                           status_valid_o,
  output logic                           auto_stop_off_o,
  output logic                           write_mode_o,
  output logic                           soft_reset_o
);
  crf_frz_type                frz_r;
  logic [7:0]                 frz_cnt_r;
  logic                       running_r;
  logic                       auto_off_r;
  logic                       gap_r;
  logic [7:0]                 gap_cnt_r;
  logic                       stretch_en_r;
  logic [4:0]                 tick_cnt_r;
  logic                       tick_r;
  logic                       run_int_r;
  logic                       run_stretched;
  logic [31:0]                btn_cnt_r;
  logic                       btn_r;
  logic                       count_en_r;
  logic                       run_r;
  logic                       gate_ok;
  logic                       auto_stop;

  // 1 us timebase for the stretcher and the button timer
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt_r <= 5'h00;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 5'(TICK_CYC - 1)) begin
      tick_cnt_r <= 5'h00;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 5'h01;
      tick_r     <= 1'b0;
    end
  end

  // freeze only this unit; a read during a freeze is served by the one in progress
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frz_r     <= CRF_IDLE;
      frz_cnt_r <= 8'h00;
    end else begin
      case (frz_r)
        CRF_IDLE: begin
          if (read_cmd_i) begin
            frz_r     <= CRF_FREEZE;
            frz_cnt_r <= 8'(FREEZE_CYC - 1);
          end
        end
        CRF_FREEZE: begin
          if (frz_cnt_r == 8'h01) begin
            frz_r <= CRF_LATCH;
          end
          frz_cnt_r <= frz_cnt_r - 8'h01;
        end
        CRF_LATCH: frz_r <= CRF_IDLE;
        default:   frz_r <= CRF_IDLE;
      endcase
    end
  end

  // count values settle after the halt, so the copy is taken in the third of the four frozen cycles
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_latch
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          latch_o[ch*CNT_W +: CNT_W] <= '0;
        end else if (frz_r == CRF_LATCH) begin
          latch_o[ch*CNT_W +: CNT_W] <= count_i[ch*CNT_W +: CNT_W];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      latch_valid_o <= 1'b0;
    end else begin
      latch_valid_o <= (frz_r == CRF_LATCH);
    end
  end

  assign gate_ok   = gate_i ^ gate_invert_i;
  assign auto_stop = limit_hit_i && !auto_off_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      auto_off_r <= 1'b0;
    end else if (auto_stop_disable_cmd_i) begin
      auto_off_r <= 1'b1;
    end else if (auto_stop_enable_cmd_i) begin
      auto_off_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      running_r <= 1'b0;
    end else if (stop_cmd_i || stop_trig_i || auto_stop) begin
      running_r <= 1'b0;
    end else if (start_cmd_i) begin
      running_r <= 1'b1;
    end
  end

  // one shared enable for counters and timer, so stop modes keep the window exact
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_en_r <= 1'b0;
    end else begin
      count_en_r <= running_r && gate_ok && frz_r == CRF_IDLE && !read_cmd_i;
    end
  end
  assign count_en_o = count_en_r;
  assign timer_en_o = count_en_r;

  // forced gap between intervals of periodic acquisition
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gap_r     <= 1'b0;
      gap_cnt_r <= 8'h00;
    end else if (interval_end_i) begin
      gap_r     <= 1'b1;
      gap_cnt_r <= 8'(RUN_GAP_CYC - 1);
    end else if (gap_cnt_r != 8'h00) begin
      gap_cnt_r <= gap_cnt_r - 8'h01;
    end else begin
      gap_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_int_r <= 1'b0;
    end else begin
      run_int_r <= running_r && !gap_r && !interval_end_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stretch_en_r <= 1'b0;
    end else if (pulse_stretch_disable_cmd_i) begin
      stretch_en_r <= 1'b0;
    end else if (pulse_stretch_enable_cmd_i) begin
      stretch_en_r <= 1'b1;
    end
  end

  crf_pulse_stretch #(
    .MIN_TICKS (STRETCH_TICKS)
  ) u_stretch (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .tick_i    (tick_r),
    .enable_i  (stretch_en_r),
    .level_i   (run_int_r),
    .level_o   (run_stretched)
  );

  // run output feeds a follower's gate input in a chain
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_r <= 1'b0;
    end else begin
      run_r <= run_stretched ^ run_invert_i;
    end
  end
  assign run_o = run_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_reply_o <= 16'h0000;
      status_valid_o <= 1'b0;
    end else begin
      status_valid_o <= pulse_stretch_status_query_i;
      if (pulse_stretch_status_query_i) begin
        status_reply_o <= stretch_en_r ? REPLY_EN : REPLY_DS;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      auto_stop_off_o <= 1'b0;
    end else begin
      auto_stop_off_o <= auto_off_r;
    end
  end

  // button timed in microseconds; write mode is entered while still held
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      btn_cnt_r    <= 32'h0000_0000;
      btn_r        <= 1'b0;
      write_mode_o <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      btn_r        <= reset_writemode_button_i;
      soft_reset_o <= 1'b0;
      if (reset_writemode_button_i) begin
        if (tick_r && btn_cnt_r < 32'(BUTTON_LIMIT)) begin
          btn_cnt_r <= btn_cnt_r + 32'h0000_0001;
        end
        if (btn_cnt_r >= 32'(BUTTON_LIMIT)) begin
          write_mode_o <= 1'b1;
        end
      end else begin
        btn_cnt_r <= 32'h0000_0000;
        if (btn_r && btn_cnt_r < 32'(BUTTON_LIMIT)) begin
          soft_reset_o <= 1'b1;
        end
      end
    end
  end

  a_freeze_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    frz_r == CRF_IDLE && read_cmd_i |=> !count_en_r [*3])
    else $error("freeze shorter than 120 ns");
  a_freeze_end: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    frz_r == CRF_IDLE && read_cmd_i && running_r && gate_ok && !stop_cmd_i
    && !stop_trig_i && !limit_hit_i ##1 (running_r && gate_ok && !read_cmd_i
    && !stop_cmd_i && !stop_trig_i && !limit_hit_i) [*4] |=> count_en_r)
    else $error("freeze did not end");
  a_timer_tied: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    timer_en_o == count_en_o)
    else $error("timer and counters not frozen together");
  a_latch_take: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    frz_r == CRF_LATCH |=> latch_o == $past(count_i) && latch_valid_o)
    else $error("holding latch not loaded");
  a_gap_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    interval_end_i |=> !run_int_r [*3])
    else $error("run gap shorter than 120 ns");
  a_no_auto: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    auto_off_r && running_r && !stop_cmd_i && !stop_trig_i |=> running_r)
    else $error("auto stop while disabled");
  a_reply_code: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pulse_stretch_status_query_i |=> status_valid_o
    && status_reply_o == ($past(stretch_en_r) ? REPLY_EN : REPLY_DS))
    else $error("wrong status reply");
  a_follow_run: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !stretch_en_r && !$past(stretch_en_r) |=> run_r == ($past(run_int_r, 2) ^ $past(run_invert_i)))
    else $error("run output not following run state");
  a_short_press: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    soft_reset_o |-> !write_mode_o)
    else $error("short press entered write mode");
endmodule

// File: verification/crf_far_side.sv
// Purpose: far side of the read-freeze block: count datapath and one chained follower
// Assumes: the follower gate is wired to the leader run output, high active
// Notes:   channel n steps by n+1 so that every channel holds a different value
`timescale 1ns/1ns
module crf_far_side
  import crf_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 count_en_i,
  input  wire logic                 run_i,
  output logic [CHANNELS*CNT_W-1:0] count_o,
  output logic [CNT_W-1:0]          follower_o
);
  // starts near the top so that the 32-bit wrap is crossed early
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    for (int c = 0; c < CHANNELS; c++) begin
      if (sys_rst_i) begin
        count_o[c*CNT_W +: CNT_W] <= 32'hFFFF_FF00 + CNT_W'(c);
      end else if (count_en_i) begin
        count_o[c*CNT_W +: CNT_W] <= count_o[c*CNT_W +: CNT_W] + CNT_W'(c + 1);
      end
    end
  end

  // follower armed beforehand with auto-stop off, counts only on the leader gate
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      follower_o <= 32'h0000_0000;
    end else if (run_i) begin
      follower_o <= follower_o + 32'h0000_0001;
    end
  end
endmodule

// File: verification/tb_counter_read_freeze_run_out.sv
// Purpose: self-checking bench for the read freeze and run output block
// Assumes: command pulses are one cycle wide, driven at the falling edge
// Notes:   button limit is shortened to 20 ticks to keep the run short
`timescale 1ns/1ns
module tb_counter_read_freeze_run_out;
  import crf_pkg::*;
  localparam int CH   = 8;
  localparam int BLIM = 20;
  logic                 clk_i     = 1'b0;
  logic                 sys_rst_i = 1'b1;
  logic [9:0]           cmd       = 10'h000;
  logic                 limit_hit = 1'b0;
  logic                 gate      = 1'b1;
  logic                 gate_inv  = 1'b0;
  logic                 button    = 1'b0;
  logic [CH*CNT_W-1:0]  count;
  logic [CH*CNT_W-1:0]  latch;
  logic                 count_en, timer_en, latch_valid, run, status_valid;
  logic                 as_off, wmode, soft_rst;
  logic [15:0]          reply;
  logic [31:0]          follow, f0;
  int                   failures = 0;
  int                   compares = 0;
  int                   n, lows, w;

  always #25 clk_i = ~clk_i;

  crf_core #(.CHANNELS(CH), .BUTTON_LIMIT(BLIM)) DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .read_cmd_i(cmd[0]), .count_i(count),
    .start_cmd_i(cmd[1]), .stop_cmd_i(cmd[2]), .stop_trig_i(cmd[3]),
    .limit_hit_i(limit_hit), .auto_stop_disable_cmd_i(cmd[4]),
    .auto_stop_enable_cmd_i(cmd[5]), .interval_end_i(cmd[6]), .gate_i(gate),
    .gate_invert_i(gate_inv), .run_invert_i(1'b0), .pulse_stretch_enable_cmd_i(cmd[7]),
    .pulse_stretch_disable_cmd_i(cmd[8]), .pulse_stretch_status_query_i(cmd[9]),
    .reset_writemode_button_i(button), .count_en_o(count_en), .timer_en_o(timer_en),
    .latch_o(latch), .latch_valid_o(latch_valid), .run_o(run), .status_reply_o(reply),
    .status_valid_o(status_valid), .auto_stop_off_o(as_off), .write_mode_o(wmode),
    .soft_reset_o(soft_rst));

  crf_far_side #(.CHANNELS(CH)) far (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .count_en_i(count_en), .run_i(run), .count_o(count), .follower_o(follow));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic check1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask
  task automatic pulse(input int idx);
    @(negedge clk_i) cmd[idx] = 1'b1;
    @(negedge clk_i) cmd[idx] = 1'b0;
  endtask
  task automatic idle(input int cyc);
    repeat (cyc) @(negedge clk_i);
  endtask
  // counts samples while the run output stays at lvl
  task automatic width(input logic lvl, output int k);
    k = 0;
    while (run === lvl && k < 1000) begin
      @(negedge clk_i);
      k++;
    end
  endtask
  task automatic status_is(input logic [15:0] exp);
    int k;
    k = 0;
    pulse(9);
    while (status_valid !== 1'b1 && k < 4) begin
      @(negedge clk_i);
      k++;
    end
    check({16'h0, reply}, {16'h0, exp});
  endtask
  task automatic freeze_read;
    f0 = follow;
    pulse(0);
    lows = 0;
    n = 0;
    while (latch_valid !== 1'b1 && n < 10) begin
      @(negedge clk_i);
      n++;
      if (count_en === 1'b0) lows++;
      check1(timer_en, count_en);
    end
    check1(lows >= FREEZE_CYC && lows <= FREEZE_CYC + 1, 1'b1);
    check1(latch_valid, 1'b1);
    for (int c = 0; c < CH; c++) check(latch[c*32 +: 32], count[c*32 +: 32]);
    check(follow - f0, 32'(n + 2));
  endtask
  task automatic summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    failures++;
    summarize();
  end

  initial begin
    idle(2);
    sys_rst_i = 1'b0;
    check({28'h0, count_en, run, latch_valid, wmode}, 32'h0);
    status_is(REPLY_DS);
    pulse(1);
    idle(4);
    check1(run, 1'b1);
    freeze_read();
    freeze_read();
    // limits are set on this leader only, never on the follower
    pulse(4);
    idle(1);
    check1(as_off, 1'b1);
    limit_hit = 1'b1;
    idle(6);
    check1(count_en, 1'b1);
    pulse(3);
    idle(4);
    check1(count_en, 1'b0);
    limit_hit = 1'b0;
    pulse(5);
    pulse(1);
    idle(4);
    limit_hit = 1'b1;
    idle(4);
    check1(run | count_en, 1'b0);
    limit_hit = 1'b0;
    pulse(1);
    idle(4);
    gate = 1'b0;
    idle(3);
    check1(count_en, 1'b0);
    gate_inv = 1'b1;
    idle(3);
    check1(count_en, 1'b1);
    gate_inv = 1'b0;
    gate = 1'b1;
    pulse(6);
    width(1'b1, w);
    width(1'b0, w);
    check1(w >= RUN_GAP_CYC && w < 50, 1'b1);
    pulse(7);
    status_is(REPLY_EN);
    idle(300);
    pulse(2);
    width(1'b1, w);
    pulse(1);
    pulse(2);
    width(1'b0, w);
    check1(w + 5 >= 200 && w + 5 <= 225, 1'b1);
    width(1'b1, w);
    check1(w + 1 >= 200 && w + 1 <= 225, 1'b1);
    pulse(8);
    status_is(REPLY_DS);
    idle(250);
    pulse(1);
    pulse(2);
    width(1'b0, w);
    width(1'b1, w);
    check1(w <= 4, 1'b1);
    button = 1'b1;
    idle(100);
    button = 1'b0;
    n = 0;
    while (soft_rst !== 1'b1 && n < 5) begin
      @(negedge clk_i);
      n++;
    end
    check1(soft_rst, 1'b1);
    check1(wmode, 1'b0);
    button = 1'b1;
    idle(BLIM * TICK_CYC + 40);
    button = 1'b0;
    idle(2);
    check1(wmode, 1'b1);
    summarize();
  end
endmodule
